// [dhbp_regs.svh]
`ifndef DHBP_REGS_SVH
`define DHBP_REGS_SVH
// modem control register index and its output-mode bit
`define DHBP_MCR_ADDR 3'h4
`define DHBP_MCR_OUT2_BIT 3
`define DHBP_MCR_RESET 8'h00
`define DHBP_ADDR_W 3
`define DHBP_DATA_W 8
`endif

// [dhbp_pkg.sv]
package dhbp_pkg;
   typedef logic [2:0] dhbp_addr_t;
   typedef logic [7:0] dhbp_byte_t;
   typedef enum logic [1:0] {DHBP_IDLE, DHBP_READ, DHBP_WRITE} dhbp_state_t;
endpackage

// [dhbp_bus_if.sv]
`timescale 1ns/1ns
interface dhbp_bus_if;
   import dhbp_pkg::*;
   dhbp_addr_t reg_select_lines;
   dhbp_byte_t host_bus_byte_h;
   logic host_bus_byte_h_oe;
   dhbp_byte_t host_bus_byte_d;
   logic host_bus_byte_d_oe;
   dhbp_byte_t host_bus_byte;
   logic read_strobe_n;
   logic write_strobe_n;
   logic chan_a_select_n;
   logic chan_b_select_n;
   logic chan_a_irq_out;
   logic chan_a_irq_oe;
   logic chan_b_irq_out;
   logic chan_b_irq_oe;
   logic chan_a_aux_out_n;
   logic chan_b_aux_out_n;
   logic chan_a_tx_ready_n;
   logic chan_a_rx_ready_n;
   logic chan_b_tx_ready_n;
   logic chan_b_rx_ready_n;
   // wire level resolved from the enables; undriven bus floats high
   assign host_bus_byte = host_bus_byte_d_oe ? host_bus_byte_d :
                          host_bus_byte_h_oe ? host_bus_byte_h : 8'hff;
   modport dev (
      input reg_select_lines, host_bus_byte, read_strobe_n, write_strobe_n,
      input chan_a_select_n, chan_b_select_n,
      output host_bus_byte_d, host_bus_byte_d_oe,
      output chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe,
      output chan_a_aux_out_n, chan_b_aux_out_n,
      output chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n
   );
   modport host (
      output reg_select_lines, host_bus_byte_h, host_bus_byte_h_oe,
      output read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
      input host_bus_byte,
      input chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe,
      input chan_a_aux_out_n, chan_b_aux_out_n,
      input chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n
   );
endinterface

// [dhbp_device.sv]
`timescale 1ns/1ns
`include "dhbp_regs.svh"
// Function
// RULE1: address lines pick register in channel
// RULE2: eight-bit shared bus, device drives reads
// RULE3: read falling edge starts read, drives byte
// RULE4: host samples at read rising edge
// RULE5: write rising edge latches bus byte
// RULE6: channel responds only when selected
// RULE7: channel A control bit 3 sets irq mode
// RULE8: channel B control bit 3 likewise
// RULE9: channel A transmit ready, active low
// RULE10: channel A receive ready, active low
// RULE11: channel B transmit ready, active low
// RULE12: channel B receive ready, active low
// RULE13: host selects one channel, holds address
// RULE14: no select means strobes ignored
module dhbp_device (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // host bus
   dhbp_bus_if.dev bus,
   // channel A register file side
   output dhbp_pkg::dhbp_addr_t a_reg_addr,
   output dhbp_pkg::dhbp_byte_t a_wr_data,
   output logic a_wr_pulse,
   output logic a_rd_pulse,
   input wire dhbp_pkg::dhbp_byte_t a_rd_data,
   input wire logic a_irq,
   input wire logic a_tx_ready,
   input wire logic a_rx_ready,
   // channel B register file side
   output dhbp_pkg::dhbp_addr_t b_reg_addr,
   output dhbp_pkg::dhbp_byte_t b_wr_data,
   output logic b_wr_pulse,
   output logic b_rd_pulse,
   input wire dhbp_pkg::dhbp_byte_t b_rd_data,
   input wire logic b_irq,
   input wire logic b_tx_ready,
   input wire logic b_rx_ready
);
   import dhbp_pkg::*;

   // ----------------------------------------
   // strobe edge detection
   // ----------------------------------------
   logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
   dhbp_state_t state_reg, state_next;
   logic chan_b_reg, chan_b_next;
   dhbp_addr_t addr_reg, addr_next;
   dhbp_byte_t dout_reg, dout_next;
   logic oe_reg, oe_next;
   logic a_rdp_reg, a_rdp_next, b_rdp_reg, b_rdp_next;
   logic a_wrp_reg, a_wrp_next, b_wrp_reg, b_wrp_next;
   dhbp_byte_t wdata_reg, wdata_next;
   dhbp_byte_t mcr_a_reg, mcr_a_next, mcr_b_reg, mcr_b_next;
   logic [5:0] pins_reg, pins_next;
   logic [1:0] aux_n_reg, aux_n_next;
   logic a_sel, b_sel;

   always_comb begin
      a_sel = !bus.chan_a_select_n;
      b_sel = !bus.chan_b_select_n;
   end

   // ----------------------------------------
   // bus cycle control
   // ----------------------------------------
   always_comb begin
      rd_n_next = bus.read_strobe_n;
      wr_n_next = bus.write_strobe_n;
      state_next = state_reg;
      chan_b_next = chan_b_reg;
      addr_next = addr_reg;
      dout_next = dout_reg;
      oe_next = oe_reg;
      a_rdp_next = 1'b0;
      b_rdp_next = 1'b0;
      a_wrp_next = 1'b0;
      b_wrp_next = 1'b0;
      wdata_next = wdata_reg;
      mcr_a_next = mcr_a_reg;
      mcr_b_next = mcr_b_reg;
      case (state_reg)
         DHBP_IDLE: begin
            oe_next = 1'b0;
            // RULE14: unselected strobes ignored
            // RULE6: select gates response
            if ((a_sel || b_sel) && rd_n_reg && !bus.read_strobe_n) begin
               // RULE3: falling read edge
               // RULE1: address latched
               state_next = DHBP_READ;
               chan_b_next = b_sel && !a_sel;
               addr_next = bus.reg_select_lines;
               a_rdp_next = a_sel;
               b_rdp_next = b_sel && !a_sel;
            end else if ((a_sel || b_sel) && wr_n_reg && !bus.write_strobe_n) begin
               // RULE5: falling write edge
               state_next = DHBP_WRITE;
               chan_b_next = b_sel && !a_sel;
               addr_next = bus.reg_select_lines;
            end
         end
         DHBP_READ: begin
            // RULE2: drive bus only on reads
            // RULE4: hold data until rising edge
            oe_next = !bus.read_strobe_n;
            dout_next = chan_b_reg ? b_rd_data : a_rd_data;
            if (bus.read_strobe_n) begin
               state_next = DHBP_IDLE;
            end
         end
         DHBP_WRITE: begin
            if (bus.write_strobe_n) begin
               // RULE5: latch on rising edge
               wdata_next = bus.host_bus_byte;
               a_wrp_next = !chan_b_reg;
               b_wrp_next = chan_b_reg;
               if (addr_reg == `DHBP_MCR_ADDR) begin
                  if (chan_b_reg) begin
                     mcr_b_next = bus.host_bus_byte;
                  end else begin
                     mcr_a_next = bus.host_bus_byte;
                  end
               end
               state_next = DHBP_IDLE;
            end
         end
         default: begin
            state_next = DHBP_IDLE;
         end
      endcase
      // RULE7: channel A output mode
      // RULE8: channel B output mode
      // RULE9: status pins, active low
      // RULE10: status pins, active low
      // RULE11: status pins, active low
      // RULE12: status pins, active low
      pins_next = {a_irq, b_irq, !a_tx_ready, !a_rx_ready, !b_tx_ready, !b_rx_ready};
      // own flop for the inverted pins, so they switch with the enables and stay glitch-free
      aux_n_next = {!mcr_a_next[`DHBP_MCR_OUT2_BIT], !mcr_b_next[`DHBP_MCR_OUT2_BIT]};
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
         state_reg <= DHBP_IDLE;
         chan_b_reg <= 1'b0;
         addr_reg <= 3'h0;
         dout_reg <= 8'h00;
         oe_reg <= 1'b0;
         a_rdp_reg <= 1'b0;
         b_rdp_reg <= 1'b0;
         a_wrp_reg <= 1'b0;
         b_wrp_reg <= 1'b0;
         wdata_reg <= 8'h00;
         mcr_a_reg <= `DHBP_MCR_RESET;
         mcr_b_reg <= `DHBP_MCR_RESET;
         pins_reg <= 6'h0f;
         aux_n_reg <= 2'b11;
      end else begin
         rd_n_reg <= rd_n_next;
         wr_n_reg <= wr_n_next;
         state_reg <= state_next;
         chan_b_reg <= chan_b_next;
         addr_reg <= addr_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
         a_rdp_reg <= a_rdp_next;
         b_rdp_reg <= b_rdp_next;
         a_wrp_reg <= a_wrp_next;
         b_wrp_reg <= b_wrp_next;
         wdata_reg <= wdata_next;
         mcr_a_reg <= mcr_a_next;
         mcr_b_reg <= mcr_b_next;
         pins_reg <= pins_next;
         aux_n_reg <= aux_n_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // mode bits are registers themselves, so the enables stay flop-driven
   assign bus.host_bus_byte_d = dout_reg;
   assign bus.host_bus_byte_d_oe = oe_reg;
   assign bus.chan_a_irq_out = pins_reg[5];
   assign bus.chan_b_irq_out = pins_reg[4];
   assign bus.chan_a_irq_oe = mcr_a_reg[`DHBP_MCR_OUT2_BIT];
   assign bus.chan_b_irq_oe = mcr_b_reg[`DHBP_MCR_OUT2_BIT];
   assign bus.chan_a_aux_out_n = aux_n_reg[1];
   assign bus.chan_b_aux_out_n = aux_n_reg[0];
   assign bus.chan_a_tx_ready_n = pins_reg[3];
   assign bus.chan_a_rx_ready_n = pins_reg[2];
   assign bus.chan_b_tx_ready_n = pins_reg[1];
   assign bus.chan_b_rx_ready_n = pins_reg[0];
   assign a_reg_addr = addr_reg;
   assign b_reg_addr = addr_reg;
   assign a_wr_data = wdata_reg;
   assign b_wr_data = wdata_reg;
   assign a_wr_pulse = a_wrp_reg;
   assign b_wr_pulse = b_wrp_reg;
   assign a_rd_pulse = a_rdp_reg;
   assign b_rd_pulse = b_rdp_reg;
endmodule

// [dhbp_host.sv]
`timescale 1ns/1ns
`include "dhbp_regs.svh"
module dhbp_host #(
   parameter int STROBE_CYCLES = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // host bus
   dhbp_bus_if.host bus,
   // user command
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic cmd_chan_b,
   input wire dhbp_pkg::dhbp_addr_t cmd_addr,
   input wire dhbp_pkg::dhbp_byte_t cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output dhbp_pkg::dhbp_byte_t rsp_rdata
);
   import dhbp_pkg::*;

   // ----------------------------------------
   // strobe sequencer
   // ----------------------------------------
   dhbp_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic phase_reg, phase_next;
   dhbp_addr_t addr_reg, addr_next;
   dhbp_byte_t wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic oe_reg, oe_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
   logic csa_n_reg, csa_n_next, csb_n_reg, csb_n_next;
   logic rdy_reg, rdy_next, rsp_reg, rsp_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      phase_next = phase_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      oe_next = oe_reg;
      rd_n_next = rd_n_reg;
      wr_n_next = wr_n_reg;
      csa_n_next = csa_n_reg;
      csb_n_next = csb_n_reg;
      rdy_next = rdy_reg;
      rsp_next = 1'b0;
      case (state_reg)
         DHBP_IDLE: begin
            if (cmd_valid && rdy_reg) begin
               // RULE13: one select, held stable
               rdy_next = 1'b0;
               addr_next = cmd_addr;
               wdata_next = cmd_wdata;
               csa_n_next = cmd_chan_b;
               csb_n_next = !cmd_chan_b;
               // RULE2: host drives bus on writes
               oe_next = cmd_write;
               state_next = cmd_write ? DHBP_WRITE : DHBP_READ;
               phase_next = 1'b0;
               cnt_next = 8'(STROBE_CYCLES);
            end
         end
         DHBP_READ, DHBP_WRITE: begin
            // phase 0: setup cycle, phase 1: strobe low
            if (!phase_reg) begin
               phase_next = 1'b1;
               rd_n_next = (state_reg != DHBP_READ);
               wr_n_next = (state_reg != DHBP_WRITE);
            end else if (cnt_reg != 8'h00) begin
               cnt_next = cnt_reg - 8'h01;
            end else begin
               // RULE4: capture at read rising edge
               if (state_reg == DHBP_READ) begin
                  rdata_next = bus.host_bus_byte;
                  rsp_next = 1'b1;
               end
               rd_n_next = 1'b1;
               wr_n_next = 1'b1;
               state_next = DHBP_IDLE;
            end
         end
         default: begin
            state_next = DHBP_IDLE;
         end
      endcase
      // release select and bus one cycle after the strobe rises
      if (state_reg == DHBP_IDLE && !rdy_reg && rd_n_reg && wr_n_reg) begin
         csa_n_next = 1'b1;
         csb_n_next = 1'b1;
         oe_next = 1'b0;
         rdy_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= DHBP_IDLE;
         cnt_reg <= 8'h00;
         phase_reg <= 1'b0;
         addr_reg <= 3'h0;
         wdata_reg <= 8'h00;
         rdata_reg <= 8'h00;
         oe_reg <= 1'b0;
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
         csa_n_reg <= 1'b1;
         csb_n_reg <= 1'b1;
         rdy_reg <= 1'b1;
         rsp_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         phase_reg <= phase_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         oe_reg <= oe_next;
         rd_n_reg <= rd_n_next;
         wr_n_reg <= wr_n_next;
         csa_n_reg <= csa_n_next;
         csb_n_reg <= csb_n_next;
         rdy_reg <= rdy_next;
         rsp_reg <= rsp_next;
      end
   end

   assign bus.reg_select_lines = addr_reg;
   assign bus.host_bus_byte_h = wdata_reg;
   assign bus.host_bus_byte_h_oe = oe_reg;
   assign bus.read_strobe_n = rd_n_reg;
   assign bus.write_strobe_n = wr_n_reg;
   assign bus.chan_a_select_n = csa_n_reg;
   assign bus.chan_b_select_n = csb_n_reg;
   assign cmd_ready = rdy_reg;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;
endmodule

// [dhbp_properties.sv]
`timescale 1ns/1ns
`include "dhbp_regs.svh"
module dhbp_properties (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // host bus
   input wire dhbp_pkg::dhbp_addr_t reg_select_lines,
   input wire dhbp_pkg::dhbp_byte_t host_bus_byte,
   input wire logic host_bus_byte_h_oe,
   input wire logic host_bus_byte_d_oe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chan_a_select_n,
   input wire logic chan_b_select_n,
   // output modes
   input wire logic chan_a_irq_oe,
   input wire logic chan_b_irq_oe,
   input wire logic chan_a_aux_out_n,
   input wire logic chan_b_aux_out_n
);
   import dhbp_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ----
   // properties
   // ----
   property p_no_fight;
      !(host_bus_byte_h_oe && host_bus_byte_d_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus driven by both ends");
   property p_drive_in_read;
      host_bus_byte_d_oe |-> !read_strobe_n || !$past(read_strobe_n, 2);
   endproperty
   a_drive_in_read: assert property (p_drive_in_read) else $error("drive outside read");
   property p_read_answer;
      $fell(read_strobe_n) && !(chan_a_select_n && chan_b_select_n) |-> ##[1:4] host_bus_byte_d_oe;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_read_low;
      $fell(read_strobe_n) |-> !read_strobe_n [*5];
   endproperty
   a_read_low: assert property (p_read_low) else $error("read strobe too short");
   property p_write_low;
      $fell(write_strobe_n) |-> !write_strobe_n [*2];
   endproperty
   a_write_low: assert property (p_write_low) else $error("write strobe too short");
   property p_one_sel;
      !(!chan_a_select_n && !chan_b_select_n);
   endproperty
   a_one_sel: assert property (p_one_sel) else $error("both channels selected");
   property p_addr_hold;
      !(read_strobe_n && write_strobe_n) && !$past(read_strobe_n && write_strobe_n)
         |-> $stable(reg_select_lines);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
   property p_aux_a;
      chan_a_aux_out_n == !chan_a_irq_oe;
   endproperty
   a_aux_a: assert property (p_aux_a) else $error("channel a aux mismatch");
   property p_aux_b;
      chan_b_aux_out_n == !chan_b_irq_oe;
   endproperty
   a_aux_b: assert property (p_aux_b) else $error("channel b aux mismatch");
   // the written bit must reach the mode output a few cycles after the strobe rises
   property p_mode_a;
      logic v;
      (!write_strobe_n && !chan_a_select_n && reg_select_lines == `DHBP_MCR_ADDR,
         v = host_bus_byte[3]) ##1 write_strobe_n |-> ##[1:4] chan_a_irq_oe == v;
   endproperty
   a_mode_a: assert property (p_mode_a) else $error("channel a mode not updated");
   property p_mode_b;
      logic v;
      (!write_strobe_n && !chan_b_select_n && reg_select_lines == `DHBP_MCR_ADDR,
         v = host_bus_byte[3]) ##1 write_strobe_n |-> ##[1:4] chan_b_irq_oe == v;
   endproperty
   a_mode_b: assert property (p_mode_b) else $error("channel b mode not updated");
   property p_no_sel_drive;
      host_bus_byte_d_oe |-> !(chan_a_select_n && chan_b_select_n);
   endproperty
   a_no_sel_drive: assert property (p_no_sel_drive) else $error("bus driven unselected");
   c_read_b: cover property (!read_strobe_n && !chan_b_select_n);
   c_both_on: cover property (chan_a_irq_oe && chan_b_irq_oe);
   c_mode_wr: cover property ($rose(write_strobe_n) && reg_select_lines == `DHBP_MCR_ADDR);
endmodule

// [dual_uart_host_bus_port_tb_top.sv]
`timescale 1ns/1ns
`include "dhbp_regs.svh"
module dual_uart_host_bus_port_tb_top;
   import dhbp_pkg::*;
   logic clk_sys, rstn, cmd_valid, cmd_write, cmd_chan_b, cmd_ready, rsp_valid;
   dhbp_addr_t cmd_addr, a_reg_addr, b_reg_addr;
   dhbp_byte_t cmd_wdata, rsp_rdata, a_wr_data, b_wr_data, a_rd_data, b_rd_data;
   logic a_wr_pulse, a_rd_pulse, b_wr_pulse, b_rd_pulse;
   logic [5:0] st;
   logic [1:0] mode;
   logic [31:0] seed;
   int n_mismatch, checks_done;
   dhbp_bus_if bus ();
   dhbp_host #(.STROBE_CYCLES(4)) i_dhbp_host (.clk_sys, .rstn, .bus(bus), .cmd_valid,
      .cmd_write, .cmd_chan_b, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata);
   dhbp_device i_dhbp_device (.clk_sys, .rstn, .bus(bus), .a_reg_addr, .a_wr_data,
      .a_wr_pulse, .a_rd_pulse, .a_rd_data, .a_irq(st[0]), .a_tx_ready(st[1]),
      .a_rx_ready(st[2]), .b_reg_addr, .b_wr_data, .b_wr_pulse, .b_rd_pulse, .b_rd_data,
      .b_irq(st[3]), .b_tx_ready(st[4]), .b_rx_ready(st[5]));
   dhbp_properties i_dhbp_properties (.clk_sys, .rstn,
      .reg_select_lines(bus.reg_select_lines), .host_bus_byte(bus.host_bus_byte),
      .host_bus_byte_h_oe(bus.host_bus_byte_h_oe), .host_bus_byte_d_oe(bus.host_bus_byte_d_oe),
      .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
      .chan_a_select_n(bus.chan_a_select_n), .chan_b_select_n(bus.chan_b_select_n),
      .chan_a_irq_oe(bus.chan_a_irq_oe), .chan_b_irq_oe(bus.chan_b_irq_oe),
      .chan_a_aux_out_n(bus.chan_a_aux_out_n), .chan_b_aux_out_n(bus.chan_b_aux_out_n));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk8(input dhbp_byte_t got, input dhbp_byte_t exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready !== 1'b1) begin
         tick();
         n++;
         if (n > 50) begin
            n_mismatch++;
            final_report();
         end
      end
   endtask
   // one command through the host; every pulse on the device user side is checked
   task automatic op(input logic w, input logic cb, input dhbp_addr_t ad, input dhbp_byte_t d);
      int n;
      logic [3:0] p;
      logic done;
      dhbp_byte_t rd;
      wait_ready();
      done = 0;
      n = 0;
      rd = cb ? b_rd_data : a_rd_data;
      {cmd_write, cmd_chan_b, cmd_addr, cmd_wdata} = {w, cb, ad, d};
      cmd_valid = 1;
      tick();
      cmd_valid = 0;
      while (!done) begin
         tick();
         n++;
         p = {b_wr_pulse, b_rd_pulse, a_wr_pulse, a_rd_pulse};
         if (p !== 4'h0) begin
            chk8({4'h0, p}, 8'h01 << {cb, w});
            chk8({5'h00, cb ? b_reg_addr : a_reg_addr}, {5'h00, ad});
            if (w) chk8(cb ? b_wr_data : a_wr_data, d);
            done = w;
         end
         if (!w && rsp_valid === 1'b1) begin
            chk8(rsp_rdata, rd);
            done = 1;
         end
         if (n > 60) begin
            n_mismatch++;
            final_report();
         end
      end
      if (w && ad == `DHBP_MCR_ADDR) mode[cb] = d[`DHBP_MCR_OUT2_BIT];
      wait_ready();
      chk1(bus.chan_a_irq_oe, mode[0]);
      chk1(bus.chan_a_aux_out_n, !mode[0]);
      chk1(bus.chan_b_irq_oe, mode[1]);
      chk1(bus.chan_b_aux_out_n, !mode[1]);
   endtask
   task automatic stat(input logic [5:0] v);
      st = v;
      repeat (3) tick();
      chk1(bus.chan_a_tx_ready_n, !v[1]);
      chk1(bus.chan_a_rx_ready_n, !v[2]);
      chk1(bus.chan_b_tx_ready_n, !v[4]);
      chk1(bus.chan_b_rx_ready_n, !v[5]);
      if (mode[0]) chk1(bus.chan_a_irq_out, v[0]);
      if (mode[1]) chk1(bus.chan_b_irq_out, v[3]);
   endtask
   // ----
   // sequence
   // ----
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      {rstn, cmd_valid, cmd_write, cmd_chan_b, cmd_addr, cmd_wdata} = '0;
      {st, mode, a_rd_data, b_rd_data, n_mismatch, checks_done} = '0;
      seed = 32'h24d1;
      repeat (10) @(posedge clk_sys);
      #1 rstn = 1;
      stat(6'h00);
      op(1, 0, 3'h4, 8'h08);
      op(1, 1, 3'h4, 8'hff);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         stat(seed[5:0]);
      end
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         {a_rd_data, b_rd_data} = seed[31:16];
         op(seed[0], seed[1], seed[4:2], seed[15:8]);
      end
      // mid-run reset must drop both channels back to three-state mode
      op(1, 0, 3'h4, 8'h08);
      op(1, 1, 3'h4, 8'h08);
      rstn = 0;
      repeat (2) tick();
      rstn = 1;
      mode = 2'b00;
      tick();
      chk1(bus.chan_a_irq_oe, 1'b0);
      chk1(bus.chan_a_aux_out_n, 1'b1);
      chk1(bus.chan_b_irq_oe, 1'b0);
      chk1(bus.chan_b_aux_out_n, 1'b1);
      op(1, 0, 3'h7, 8'hff);
      op(0, 1, 3'h0, 8'h00);
      op(1, 0, 3'h4, 8'hf7);
      op(1, 1, 3'h4, 8'h00);
      stat(6'h3f);
      final_report();
   end
endmodule
